// ### pin_mux_pkg.sv
// Constants and types for the port D / port E pin function select block
package pin_mux_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam int          PORT_W         = 16;
    localparam logic [7:0]  OFS_PD_SEL     = 8'h00;
    localparam logic [7:0]  OFS_PE_DIR     = 8'h04;
    localparam logic [7:0]  OFS_PE_UPPER   = 8'h08;
    localparam logic [7:0]  OFS_PE_LOWER   = 8'h0c;
    localparam logic [7:0]  OFS_PD_STATUS  = 8'h10;
    localparam logic [7:0]  OFS_PE_STATUS  = 8'h14;
    localparam logic [15:0] PD_SEL_RESET   = 16'h0000;
    localparam logic [15:0] PE_DIR_RESET   = 16'h0000;
    localparam logic [15:0] PE_UPPER_RESET = 16'h0000;
    localparam logic [15:0] PE_LOWER_RESET = 16'h0000;
    localparam logic [15:0] PE_UPPER_MASK  = 16'hfd55;
    localparam logic [15:0] PE_LOWER_MASK  = 16'h55ff;
    localparam logic [15:0] PE_WIDE_FIELDS = 16'he00f;
    localparam int          PE_DMA_ACKNOWLEDGE_CH1_PIN   = 15;
    localparam int          PE_AH_PIN      = 14;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {
        FUNC_GPIO  = 2'b00,
        FUNC_TIMER = 2'b01,
        FUNC_ALT_A = 2'b10,
        FUNC_ALT_B = 2'b11
    } pe_func_t;
endpackage

// ### pe_pin_mux.sv
// Output driver select for one port E pin
`timescale 1ns/1ps
module pe_pin_mux
    import pin_mux_pkg::*;
(
    // Function and direction
    input  wire pin_mux_pkg::pe_func_t func_i,
    input  wire logic                  dir_i,
    // Candidate drivers
    input  wire logic                  gpio_out_i,
    input  wire logic                  timer_out_i,
    input  wire logic                  alt_out_i,
    input  wire logic                  alt_oe_i,
    // Pin
    output logic                       pin_o,
    output logic                       pin_oe_o
);
    import pin_mux_pkg::*;

    always_comb begin
        unique case (func_i)
            FUNC_GPIO: begin
                pin_o    = gpio_out_i;
                pin_oe_o = dir_i;
            end
            FUNC_TIMER: begin
                pin_o    = timer_out_i;
                pin_oe_o = dir_i;
            end
            FUNC_ALT_A, FUNC_ALT_B: begin
                pin_o    = alt_out_i;
                pin_oe_o = alt_oe_i;
            end
        endcase
    end
endmodule

// ### pin_mux_top.sv
// Port D low / port E pin function select with AXI4-Lite registers
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pin_mux_top
    import pin_mux_pkg::*;
(
    // Clock and resets
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       warm_rst_i,
    // Operating mode
    input  wire logic                       single_chip_i,
    input  wire logic                       rom_enabled_i,
    // AXI4-Lite write
    input  wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [pin_mux_pkg::DATA_W-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic [1:0]                      s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic [pin_mux_pkg::DATA_W-1:0]  s_axi_rdata_o,
    output logic [1:0]                      s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i,
    // Port D pins and sources
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pd_pin_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  pd_pin_o,
    output logic [pin_mux_pkg::PORT_W-1:0]  pd_pin_oe_o,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pd_gpio_out_i,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pd_gpio_oe_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  pd_gpio_in_o,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] bus_data_out_i,
    input  wire logic                       bus_data_oe_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  bus_data_in_o,
    output logic [pin_mux_pkg::PORT_W-1:0]  pd_bus_sel_o,
    // Port E pins and sources
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pe_pin_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  pe_pin_o,
    output logic [pin_mux_pkg::PORT_W-1:0]  pe_pin_oe_o,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pe_gpio_out_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  pe_gpio_in_o,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] timer_out_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  timer_in_o,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] alt_out_i,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] alt_oe_i,
    output logic [pin_mux_pkg::PORT_W-1:0]  alt_in_o,
    output logic [2*pin_mux_pkg::PORT_W-1:0] pe_func_o
);
    import pin_mux_pkg::*;

    logic [PORT_W-1:0]   pd_sel_ff;
    logic [PORT_W-1:0]   pe_dir_ff;
    logic [PORT_W-1:0]   pe_upper_ff;
    logic [PORT_W-1:0]   pe_lower_ff;
    logic                aw_held_ff;
    logic [ADDR_W-1:0]   aw_addr_ff;
    logic                w_held_ff;
    logic [PORT_W-1:0]   w_data_ff;
    logic [1:0]          w_strb_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;
    logic                rvalid_ff;
    logic [DATA_W-1:0]   rdata_ff;
    logic [1:0]          rresp_ff;
    logic                bus_rst;
    logic                do_write;
    logic [ADDR_W-1:0]   wr_addr;
    logic [ADDR_W-1:0]   rd_addr;
    logic [PORT_W-1:0]   wr_mask;
    logic                wr_hit;
    logic [PORT_W-1:0]   pd_sel_eff;
    logic [2*PORT_W-1:0] pe_ctrl_cat;
    logic [DATA_W-1:0]   nxt_rdata;
    logic [1:0]          nxt_rresp;

    // Bus side only; mode registers survive warm resets
    assign bus_rst  = !nrst_i || warm_rst_i;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_addr  = {aw_addr_ff[ADDR_W-1:2], 2'b00};
    assign rd_addr  = {s_axi_araddr_i[ADDR_W-1:2], 2'b00};
    assign wr_mask  = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    assign wr_hit   = (wr_addr == OFS_PD_SEL) || (wr_addr == OFS_PE_DIR)
                   || (wr_addr == OFS_PE_UPPER) || (wr_addr == OFS_PE_LOWER);

    assign s_axi_awready_o = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready_o  = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid_o  = bvalid_ff;
    assign s_axi_bresp_o   = bresp_ff;
    assign s_axi_arready_o = !rvalid_ff;
    assign s_axi_rvalid_o  = rvalid_ff;
    assign s_axi_rdata_o   = rdata_ff;
    assign s_axi_rresp_o   = rresp_ff;

    // Address and data may arrive in either order
    always_ff @(posedge clk_i) begin
        if (bus_rst) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (bus_rst) begin
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata_i[PORT_W-1:0];
            w_strb_ff <= s_axi_wstrb_i[1:0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (bus_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Only power-on reset clears these
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pd_sel_ff <= PD_SEL_RESET;
        end else if (do_write && wr_addr == OFS_PD_SEL) begin
            pd_sel_ff <= (pd_sel_ff & ~wr_mask) | (w_data_ff & wr_mask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pe_dir_ff <= PE_DIR_RESET;
        end else if (do_write && wr_addr == OFS_PE_DIR) begin
            pe_dir_ff <= (pe_dir_ff & ~wr_mask) | (w_data_ff & wr_mask);
        end
    end

    // Reserved bits are never stored, so they read as zero
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pe_upper_ff <= PE_UPPER_RESET;
        end else if (do_write && wr_addr == OFS_PE_UPPER) begin
            pe_upper_ff <= ((pe_upper_ff & ~wr_mask) | (w_data_ff & wr_mask))
                         & PE_UPPER_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pe_lower_ff <= PE_LOWER_RESET;
        end else if (do_write && wr_addr == OFS_PE_LOWER) begin
            pe_lower_ff <= ((pe_lower_ff & ~wr_mask) | (w_data_ff & wr_mask))
                         & PE_LOWER_MASK;
        end
    end

    always_comb begin
        nxt_rdata = '0;
        nxt_rresp = RESP_OKAY;
        unique case (rd_addr)
            OFS_PD_SEL:    nxt_rdata[PORT_W-1:0] = pd_sel_ff;
            OFS_PE_DIR:    nxt_rdata[PORT_W-1:0] = pe_dir_ff;
            OFS_PE_UPPER:  nxt_rdata[PORT_W-1:0] = pe_upper_ff;
            OFS_PE_LOWER:  nxt_rdata[PORT_W-1:0] = pe_lower_ff;
            OFS_PD_STATUS: nxt_rdata[PORT_W-1:0] = pd_sel_eff;
            OFS_PE_STATUS: nxt_rdata[PORT_W-1:0] = pe_pin_oe_o;
            default:       nxt_rresp = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (bus_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end else if (s_axi_rready_i) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Both ports read the pin level regardless of who drives it
    assign pd_gpio_in_o  = pd_pin_i;
    assign bus_data_in_o = pd_pin_i;
    assign pe_gpio_in_o  = pe_pin_i;
    assign timer_in_o    = pe_pin_i;
    assign alt_in_o      = pe_pin_i;
    assign pd_bus_sel_o  = pd_sel_eff;
    // Field of pin n sits at bit 2n of the joined pair
    assign pe_ctrl_cat   = {pe_upper_ff, pe_lower_ff};

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            logic [1:0] raw_code;
            pe_func_t   func_eff;

            // Mode first, then select bit
            assign pd_sel_eff[gi] = single_chip_i ? 1'b0
                                  : !rom_enabled_i ? 1'b1
                                  : pd_sel_ff[gi];
            assign pd_pin_o[gi]    = pd_sel_eff[gi] ? bus_data_out_i[gi]
                                                    : pd_gpio_out_i[gi];
            assign pd_pin_oe_o[gi] = pd_sel_eff[gi] ? bus_data_oe_i
                                                    : pd_gpio_oe_i[gi];

            assign raw_code = PE_WIDE_FIELDS[gi] ? pe_ctrl_cat[2*gi+1 -: 2]
                                                 : {1'b0, pe_ctrl_cat[2*gi]};
            // Strobe and acknowledge settings fall back to I/O in single-chip
            assign func_eff = (single_chip_i && raw_code[1]
                               && (gi == PE_DMA_ACKNOWLEDGE_CH1_PIN || gi == PE_AH_PIN))
                            ? FUNC_GPIO : pe_func_t'(raw_code);
            assign pe_func_o[2*gi+1 -: 2] = func_eff;

            pe_pin_mux u_pe_pin (
                .func_i      (func_eff),
                .dir_i       (pe_dir_ff[gi]),
                .gpio_out_i  (pe_gpio_out_i[gi]),
                .timer_out_i (timer_out_i[gi]),
                .alt_out_i   (alt_out_i[gi]),
                .alt_oe_i    (alt_oe_i[gi]),
                .pin_o       (pe_pin_o[gi]),
                .pin_oe_o    (pe_pin_oe_o[gi])
            );
        end
    endgenerate
endmodule

// ### pin_mux_sva.sv
// Checker for the bus handshake and pin routing of the pin mux top
`timescale 1ns/1ps
module pin_mux_sva (
    // Clock, resets, mode
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        warm_rst_i,
    input wire logic        single_chip_i,
    input wire logic        rom_enabled_i,
    // Bus handshake
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // Pins
    input wire logic [15:0] pd_pin_oe_o,
    input wire logic        bus_data_oe_i,
    input wire logic [15:0] pd_bus_sel_o,
    input wire logic [31:0] pe_func_o,
    input wire logic [15:0] pe_pin_oe_o,
    input wire logic [15:0] alt_oe_i
);
    default clocking @(posedge clk_i); endclocking
    // Warm reset drops bus state, so every check, pin checks included, pauses with it
    default disable iff (!nrst_i || warm_rst_i);
    sequence s_wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    a_write_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid_o)
        else $error("write response not two cycles after taking");
    a_write_block: assert property (s_wr_taken |=> !s_axi_awready_o [*2])
        else $error("address accepted while a write is open");
    a_read_resp: assert property (s_rd_taken |=> s_axi_rvalid_o)
        else $error("read data not one cycle after taking");
    a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped before ready");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data changed before ready");
    a_rdata_width: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_pd_single: assert property (single_chip_i |-> pd_bus_sel_o == 16'h0000)
        else $error("port d bus line in single-chip mode");
    a_pd_no_rom: assert property (!single_chip_i && !rom_enabled_i
        |-> pd_bus_sel_o == 16'hffff)
        else $error("port d not bus with program memory off");
    a_pd_bus_oe: assert property (((pd_pin_oe_o ^ {16{bus_data_oe_i}}) & pd_bus_sel_o)
        == 16'h0000)
        else $error("bus-routed port d pin not driven by bus enable");
    a_pe_alt_oe: assert property (pe_func_o[31] |-> pe_pin_oe_o[15] == alt_oe_i[15])
        else $error("direction bit steers a non-gpio pin");
    a_pe_override: assert property (single_chip_i |-> !pe_func_o[31] && !pe_func_o[29])
        else $error("strobe or acknowledge kept in single-chip mode");
    a_reset_clear: assert property ($rose(nrst_i) |-> pe_func_o == 32'h0)
        else $error("function control not cleared by reset");
endmodule

bind pin_mux_top pin_mux_sva chk_u (.clk_i, .nrst_i, .warm_rst_i, .single_chip_i,
    .rom_enabled_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .s_axi_rdata_o, .pd_pin_oe_o, .bus_data_oe_i, .pd_bus_sel_o,
    .pe_func_o, .pe_pin_oe_o, .alt_oe_i);

// ### pin_far_end.sv
// Far-side pad model: resolves port D and port E pad levels
`timescale 1ns/1ps
module pin_far_end (
    // Clock
    input  wire logic        clk_i,
    // Block drive
    input  wire logic [15:0] pd_pin_o,
    input  wire logic [15:0] pd_pin_oe_o,
    input  wire logic [15:0] pe_pin_o,
    input  wire logic [15:0] pe_pin_oe_o,
    // Pad levels
    output logic      [15:0] pd_pin_i,
    output logic      [15:0] pe_pin_i
);
    logic [15:0] idle_ff = 16'h5a5a;
    // No pulls here, so an undriven pad flips every cycle
    always @(posedge clk_i) idle_ff <= ~idle_ff;
    assign pd_pin_i = (pd_pin_o & pd_pin_oe_o) | (idle_ff & ~pd_pin_oe_o);
    assign pe_pin_i = (pe_pin_o & pe_pin_oe_o) | (~idle_ff & ~pe_pin_oe_o);
endmodule

// ### test_port_d_low_e_pin_function_select.sv
// Self-checking bench for the port D / port E pin function select block
`timescale 1ns/1ps
module test_port_d_low_e_pin_function_select;
    import pin_mux_pkg::*;
    logic        clk_i, nrst_i, warm_rst_i, single_chip_i, rom_enabled_i, bus_data_oe_i;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic        s_axi_rvalid_o, s_axi_rready_i;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, pe_func_o, q;
    logic [3:0]  s_axi_wstrb_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
    logic [15:0] pd_pin_i, pd_pin_o, pd_pin_oe_o, pd_gpio_out_i, pd_gpio_oe_i, pd_gpio_in_o;
    logic [15:0] bus_data_out_i, bus_data_in_o, pd_bus_sel_o, pe_pin_i, pe_pin_o, pe_pin_oe_o;
    logic [15:0] pe_gpio_out_i, pe_gpio_in_o, timer_out_i, timer_in_o, alt_out_i, alt_oe_i;
    logic [15:0] alt_in_o;
    logic [15:0] m [4];
    logic [15:0] msk [4] = '{16'hffff, 16'hffff, PE_UPPER_MASK, PE_LOWER_MASK};
    logic [7:0]  ofs [4] = '{OFS_PD_SEL, OFS_PE_DIR, OFS_PE_UPPER, OFS_PE_LOWER};
    int          failures = 0;
    int          n_tests = 0;
    int          seed = 32'h214c52b8;

    pin_mux_top dut_u (.*);
    pin_far_end far_u (.*);

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One bus transfer; ready is sampled at the falling edge before the taking edge
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] qo, output logic [1:0] ro);
        bit fa, fw, fr, fin;
        fin = 1'b0;
        @(posedge clk_i);
        if (wr) begin
            {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
            {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
        end else begin
            s_axi_araddr_i <= a;
            {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
        end
        repeat (40) if (!fin) begin
            @(negedge clk_i);
            fa = s_axi_awvalid_i && s_axi_awready_o;
            fw = s_axi_wvalid_i && s_axi_wready_o;
            fr = s_axi_arvalid_i && s_axi_arready_o;
            fin = wr ? s_axi_bvalid_o : s_axi_rvalid_o;
            ro = wr ? s_axi_bresp_o : s_axi_rresp_o;
            qo = s_axi_rdata_o;
            @(posedge clk_i);
            if (fa) s_axi_awvalid_i <= 1'b0;
            if (fw) s_axi_wvalid_i <= 1'b0;
            if (fr) s_axi_arvalid_i <= 1'b0;
            if (fin) {s_axi_bready_i, s_axi_rready_i} <= 2'b00;
        end
        if (!fin) begin
            failures++;
            summarize();
        end
    endtask

    task automatic wr(input int idx, input logic [31:0] d);
        axi(1'b1, ofs[idx], d, q, r);
        m[idx] = d[15:0] & msk[idx];
        check(r, RESP_OKAY);
    endtask

    task automatic rd_all();
        for (int k = 0; k < 4; k++) begin
            axi(1'b0, ofs[k], 32'h0, q, r);
            check(q, {16'h0000, m[k]});
            check(r, RESP_OKAY);
        end
    endtask

    task automatic stir();
        {pd_gpio_out_i, pd_gpio_oe_i} <= $random(seed);
        {bus_data_out_i, pe_gpio_out_i} <= $random(seed);
        {timer_out_i, alt_out_i} <= $random(seed);
        {alt_oe_i, bus_data_oe_i} <= 17'($random(seed));
    endtask

    task automatic pins();
        logic [31:0] f;
        logic [15:0] sel, oe, po;
        sel = single_chip_i ? 16'h0000 : (!rom_enabled_i ? 16'hffff : m[0]);
        check(pd_bus_sel_o, sel);
        oe = ({16{bus_data_oe_i}} & sel) | (pd_gpio_oe_i & ~sel);
        check(pd_pin_oe_o, oe);
        check(pd_pin_o & oe, ((bus_data_out_i & sel) | (pd_gpio_out_i & ~sel)) & oe);
        f = {m[2], m[3]};
        if (single_chip_i && f[31]) f[31:30] = 2'b00;
        if (single_chip_i && f[29]) f[29:28] = 2'b00;
        for (int n = 0; n < 16; n++) begin
            oe[n] = f[2*n+1] ? alt_oe_i[n] : m[1][n];
            po[n] = f[2*n+1] ? alt_out_i[n] : (f[2*n] ? timer_out_i[n] : pe_gpio_out_i[n]);
        end
        check(pe_func_o, f);
        check(pe_pin_oe_o, oe);
        check(pe_pin_o & oe, po & oe);
        check(pd_gpio_in_o, pd_pin_i);
        check(bus_data_in_o, pd_pin_i);
        check({pe_gpio_in_o, timer_in_o}, {pe_pin_i, pe_pin_i});
        check(alt_in_o, pe_pin_i);
        // Status views follow mode and sources, read while they stand still
        axi(1'b0, OFS_PD_STATUS, 32'h0, q, r);
        check(q, {16'h0000, sel});
        axi(1'b0, OFS_PE_STATUS, 32'h0, q, r);
        check(q, {16'h0000, oe});
    endtask

    initial begin
        {nrst_i, warm_rst_i, single_chip_i, bus_data_oe_i, s_axi_awvalid_i} = '0;
        {s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, pd_gpio_out_i, pd_gpio_oe_i} = '0;
        {bus_data_out_i, pe_gpio_out_i, timer_out_i, alt_out_i, alt_oe_i} = '0;
        rom_enabled_i = 1'b1;
        s_axi_wstrb_i = 4'h3;
        m = '{default: 16'h0000};
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_all();
        $display("reset values done");
        for (int j = 0; j < 6; j++) begin
            for (int i = 0; i < 4; i++) wr(i, $random(seed));
            rd_all();
            for (int i = 0; i < 4; i++) begin
                @(posedge clk_i);
                {single_chip_i, rom_enabled_i} <= i[1:0];
                stir();
                @(negedge clk_i);
                pins();
            end
        end
        $display("routing and modes done");
        @(posedge clk_i);
        warm_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        warm_rst_i <= 1'b0;
        rd_all();
        $display("warm reset done");
        axi(1'b1, OFS_PD_STATUS, 32'hffff, q, r);
        check(r, RESP_SLVERR);
        axi(1'b0, 8'h18, 32'h0, q, r);
        check(q, 32'h0);
        check(r, RESP_SLVERR);
        // Upper lane only; the low byte must keep its value
        s_axi_wstrb_i <= 4'h2;
        axi(1'b1, OFS_PE_DIR, 32'h0000a5c3, q, r);
        m[1][15:8] = 8'ha5;
        check(r, RESP_OKAY);
        s_axi_wstrb_i <= 4'h3;
        rd_all();
        $display("refusals done");
        @(posedge clk_i);
        nrst_i <= 1'b0;
        @(posedge clk_i);
        nrst_i <= 1'b1;
        m = '{default: 16'h0000};
        rd_all();
        $display("second reset done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        summarize();
    end
endmodule
